// [dv/spw_host_model.sv]
// Purpose: host side that acknowledges pending interrupt flags
// Assumes: write-one clear pulses one cycle wide
// Notes:   clears only what it saw pending, as a polling host would
`timescale 1ns/10ps
module spw_host_model (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                clear_req,
  input  wire spw_pkg::spw_flags_t flags,
  output spw_pkg::spw_flags_t      flag_clear
);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) flag_clear <= '0;
    else flag_clear <= clear_req ? flags : '0;
  end
endmodule : spw_host_model

// [dv/spw_supervisor_asserts.sv]
// Purpose: port-level assertions for the power/wake supervisor
// Assumes: one clock, asynchronous active-high reset
// Notes:   bound into every supervisor instance from tb_top
`timescale 1ns/10ps
module spw_supervisor_asserts #(
  parameter int unsigned TXD_TIMEOUT = 8
) (
  input wire logic                clk,
  input wire logic                sys_rst,
  input wire logic                battery_above_poff,
  input wire logic                battery_above_pon,
  input wire logic                overtemp_detect,
  input wire logic                transceiver_standby_bit,
  input wire logic                dissipation_split_bit,
  input wire logic                bus_transmit_input,
  input wire logic                bus_drive_dominant,
  input wire logic                transceiver_active,
  input wire logic                regulator_enable,
  input wire logic                pass_threshold_low,
  input wire logic                reset_pin_low_oe,
  input wire logic                interrupt_out_low_oe,
  input wire logic                limp_home_control_bit,
  input wire spw_pkg::spw_flags_t flags,
  input wire spw_pkg::spw_mode_t  mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] low_cnt;
  logic       awake;
  assign awake = mode == spw_pkg::SPW_STANDBY || mode == spw_pkg::SPW_NORMAL;
  // saturates so a stuck-low input never wraps back under the limit
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) low_cnt <= 8'h00;
    else if (bus_transmit_input) low_cnt <= 8'h00;
    else if (low_cnt != 8'hFF) low_cnt <= low_cnt + 8'h01;
  end
  sequence s_hot;
    awake && overtemp_detect && battery_above_poff;
  endsequence
  sequence s_cool;
    mode == spw_pkg::SPW_OVERTEMP && !overtemp_detect && battery_above_poff;
  endsequence
  AST_OFF: assert property (!battery_above_poff |=> mode == spw_pkg::SPW_OFF)
    else $error("mode not off after battery loss");
  AST_PON: assert property (mode == spw_pkg::SPW_OFF && battery_above_poff && battery_above_pon
    |=> mode == spw_pkg::SPW_STANDBY && flags.power_on_flag) else $error("no power-on entry");
  AST_PASS: assert property (pass_threshold_low == dissipation_split_bit)
    else $error("pass threshold wrong");
  AST_ACT: assert property (transceiver_active
    |-> mode == spw_pkg::SPW_NORMAL && !transceiver_standby_bit) else $error("bad active");
  AST_TXD: assert property (low_cnt > TXD_TIMEOUT + 4 |-> !bus_drive_dominant)
    else $error("transmitter still driving");
  AST_INT: assert property (interrupt_out_low_oe == (flags != '0))
    else $error("interrupt pin wrong");
  AST_OTIN: assert property (s_hot |=> mode == spw_pkg::SPW_OVERTEMP)
    else $error("no overtemp entry");
  AST_OTHOLD: assert property (mode == spw_pkg::SPW_OVERTEMP |-> limp_home_control_bit
    && reset_pin_low_oe && !regulator_enable && !bus_drive_dominant) else $error("hot outputs");
  AST_OTOUT: assert property (s_cool |=> mode == spw_pkg::SPW_STANDBY)
    else $error("no overtemp exit");
endmodule : spw_supervisor_asserts

// [dv/tb_top.sv]
// Purpose: self-checking bench for the power/wake supervisor
// Assumes: shortened timing parameters
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/10ps
module tb_top;
  localparam int unsigned TXD = 8;
  logic clk = 1'h0, sys_rst = 1'h1, battery_above_poff = 1'h0, battery_above_pon = 1'h0;
  logic battery_above_bus_uv = 1'h1, regulator_above_90 = 1'h1, regulator_above_70 = 1'h1;
  logic overtemp_detect = 1'h0, mode_write = 1'h0, transceiver_standby_bit = 1'h0;
  logic [1:0] device_mode_field = 2'h0, wake_a_edge_config = 2'h0, wake_b_edge_config = 2'h0;
  logic dissipation_split_bit = 1'h0, reset_threshold_select = 1'h0, limp_clear = 1'h0;
  logic wake_a_sample_enable = 1'h0, wake_b_sample_enable = 1'h0, clear_req = 1'h0;
  logic wake_bias_period_select = 1'h0, local_wake_pin_a = 1'h0, local_wake_pin_b = 1'h0;
  logic bus_transmit_input = 1'h1, bus_dominant = 1'h0, watchdog_disable_pin = 1'h0;
  logic watchdog_timeout_mode = 1'h0, watchdog_overflow = 1'h0, bus_receive_output;
  logic bus_drive_dominant, transceiver_active, transceiver_lowpower, transceiver_off;
  logic regulator_enable, pass_threshold_low, regulator_state_bit, reset_pin_low_o;
  logic reset_pin_low_oe, interrupt_out_low_o, interrupt_out_low_oe, limp_home_control_bit;
  logic wake_bias_strobe, wake_a_level_status, wake_b_level_status;
  spw_pkg::spw_flags_t flag_clear, flags;
  spw_pkg::spw_mode_t  mode;
  int num_errors = 0;
  int total_checks = 0;
  int rises;
  always #2 clk = ~clk;
  spw_supervisor #(.TXD_TIMEOUT(TXD), .BUS_WAKE_MIN(8), .BIAS_SHORT(16), .BIAS_LONG(64))
    dut_u (.*);
  spw_host_model host_u (.clk, .sys_rst, .clear_req, .flags, .flag_clear);
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic set_mode(input logic [1:0] m);
    device_mode_field = m;
    mode_write = 1'h1;
    step(1);
    mode_write = 1'h0;
    step(2);
  endtask : set_mode
  task automatic clr;
    clear_req = 1'h1;
    step(1);
    clear_req = 1'h0;
    step(2);
  endtask : clr
  task automatic pins(input logic v);
    local_wake_pin_a = v;
    local_wake_pin_b = v;
    step(6);
  endtask : pins
  task automatic ovf;
    watchdog_overflow = 1'h1;
    step(1);
    watchdog_overflow = 1'h0;
  endtask : ovf
  // bounded waits; running out ends the run with the report
  task automatic wait_mode(input spw_pkg::spw_mode_t m);
    for (int i = 0; i < 8 && mode !== m; i++) step(1);
    chk(mode, m);
    if (mode !== m) finish_test();
  endtask : wait_mode
  task automatic wait_rst;
    for (int i = 0; i < 8 && reset_pin_low_oe !== 1'h1; i++) step(1);
    chk(reset_pin_low_oe, 8'h01);
    if (reset_pin_low_oe !== 1'h1) finish_test();
  endtask : wait_rst
  task automatic wait_bias(input logic v);
    for (int i = 0; i < 70 && wake_bias_strobe !== v; i++) step(1);
    chk(wake_bias_strobe, {7'h00, v});
    if (wake_bias_strobe !== v) finish_test();
  endtask : wait_bias
  // counts strobe rising edges over n whole cycles
  task automatic count_rises(input int n);
    logic prev_lvl;
    prev_lvl = wake_bias_strobe;
    rises = 0;
    repeat (n) begin
      step(1);
      if (wake_bias_strobe && !prev_lvl) rises++;
      prev_lvl = wake_bias_strobe;
    end
  endtask : count_rises
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    step(5);
    sys_rst = 1'h0;
    step(2);
    chk(mode, spw_pkg::SPW_OFF);
    battery_above_poff = 1'h1;
    battery_above_pon = 1'h1;
    step(2);
    chk(flags, 8'h20);
    chk(interrupt_out_low_oe, 8'h01);
    clr();
    chk(interrupt_out_low_oe, 8'h00);
    dissipation_split_bit = 1'h1;
    set_mode(2'h3);
    chk(transceiver_active, 8'h01);
    battery_above_bus_uv = 1'h0;
    bus_dominant = 1'h1;
    step(4);
    chk(transceiver_active, 8'h00);
    battery_above_bus_uv = 1'h1;
    step(4);
    chk(bus_receive_output, 8'h00);
    bus_dominant = 1'h0;
    bus_transmit_input = 1'h0;
    step(TXD);
    chk(bus_receive_output, 8'h01);
    chk(bus_drive_dominant, 8'h01);
    step(5);
    chk(bus_drive_dominant, 8'h00);
    bus_transmit_input = 1'h1;
    transceiver_standby_bit = 1'h1;
    bus_dominant = 1'h1;
    step(4);
    bus_dominant = 1'h0;
    step(4);
    chk(flags.bus_wakeup_flag, 8'h00);
    chk(transceiver_lowpower, 8'h01);
    bus_dominant = 1'h1;
    step(20);
    bus_dominant = 1'h0;
    chk(flags.bus_wakeup_flag, 8'h01);
    clr();
    transceiver_standby_bit = 1'h0;
    set_mode(2'h2);
    set_mode(2'h0);
    chk(transceiver_off, 8'h01);
    for (int c = 0; c < 4; c++) begin
      wake_a_edge_config = c[1:0];
      wake_b_edge_config = c[1:0];
      pins(1'h1);
      chk(flags.wake_flag, c[0] ? 8'h03 : 8'h00);
      chk({wake_a_level_status, wake_b_level_status}, (c != 0) ? 8'h03 : 8'h00);
      clr();
      pins(1'h0);
      chk(flags.wake_flag, c[1] ? 8'h03 : 8'h00);
      clr();
    end
    set_mode(2'h1);
    chk(mode, spw_pkg::SPW_SLEEP);
    pins(1'h1);
    wait_mode(spw_pkg::SPW_STANDBY);
    clr();
    reset_threshold_select = 1'h1;
    regulator_above_90 = 1'h0;
    step(3);
    chk(flags.regulator_undervoltage_warning, 8'h01);
    chk(regulator_state_bit, 8'h00);
    chk(reset_pin_low_oe, 8'h00);
    reset_threshold_select = 1'h0;
    wait_rst();
    regulator_above_90 = 1'h1;
    clr();
    watchdog_timeout_mode = 1'h1;
    step(2);
    ovf();
    step(2);
    chk(flags.cyclic_interrupt, 8'h01);
    ovf();
    wait_rst();
    overtemp_detect = 1'h1;
    wait_mode(spw_pkg::SPW_OVERTEMP);
    chk(limp_home_control_bit, 8'h01);
    overtemp_detect = 1'h0;
    wait_mode(spw_pkg::SPW_STANDBY);
    limp_clear = 1'h1;
    step(1);
    limp_clear = 1'h0;
    step(1);
    chk(limp_home_control_bit, 8'h00);
    chk({reset_pin_low_o, interrupt_out_low_o}, 8'h00);
    count_rises(64);
    chk(rises[7:0], 8'h04);
    wake_bias_period_select = 1'h1;
    step(64);
    count_rises(128);
    chk(rises[7:0], 8'h02);
    wake_bias_period_select = 1'h0;
    wait_bias(1'h1);
    wait_bias(1'h0);
    wake_a_sample_enable = 1'h1;
    local_wake_pin_a = 1'h0;
    local_wake_pin_b = 1'h0;
    step(4);
    chk(flags.wake_flag, 8'h02);
    wait_bias(1'h1);
    chk(flags.wake_flag, 8'h03);
    battery_above_poff = 1'h0;
    battery_above_pon = 1'h0;
    step(2);
    chk(mode, spw_pkg::SPW_OFF);
    chk(regulator_enable, 8'h00);
    finish_test();
  end
endmodule : tb_top

bind spw_supervisor spw_supervisor_asserts #(.TXD_TIMEOUT(TXD_TIMEOUT)) chk_u (.*);

// [rtl/spw_pkg.sv]
// Purpose: shared constants and carriers for the power/wake supervisor
// Assumes: 250 MHz system clock
// Notes:   timing counts are derived from times in their own units
package spw_pkg;

  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned TXD_TIMEOUT_US   = 20;
  localparam int unsigned TXD_TIMEOUT_CYC  = TXD_TIMEOUT_US * CLK_MHZ;
  localparam int unsigned BUS_WAKE_MIN_US  = 30;
  localparam int unsigned BUS_WAKE_MIN_CYC = BUS_WAKE_MIN_US * CLK_MHZ;
  localparam int unsigned BIAS_SHORT_MS    = 16;
  localparam int unsigned BIAS_LONG_MS     = 64;
  localparam int unsigned BIAS_SHORT_CYC   = BIAS_SHORT_MS * 1000 * CLK_MHZ;
  localparam int unsigned BIAS_LONG_CYC    = BIAS_LONG_MS * 1000 * CLK_MHZ;
  localparam int unsigned PASS_ON_MA_LO    = 85;
  localparam int unsigned PASS_ON_MA_HI    = 50;
  localparam int unsigned TMR_W            = 25;

  // device mode field encodings
  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_SLEEP   = 2'h1;

  // wake edge configuration encodings
  localparam logic [1:0] WCFG_OFF  = 2'h0;
  localparam logic [1:0] WCFG_RISE = 2'h1;
  localparam logic [1:0] WCFG_FALL = 2'h2;
  localparam logic [1:0] WCFG_BOTH = 2'h3;

  typedef enum logic [2:0] {
    SPW_OFF      = 3'b000,
    SPW_STANDBY  = 3'b001,
    SPW_NORMAL   = 3'b010,
    SPW_SLEEP    = 3'b011,
    SPW_OVERTEMP = 3'b100
  } spw_mode_t;

  typedef struct packed {
    logic       power_on_flag;
    logic       regulator_undervoltage_warning;
    logic       bus_wakeup_flag;
    logic       cyclic_interrupt;
    logic [1:0] wake_flag;
  } spw_flags_t;

endpackage : spw_pkg

// [rtl/spw_supervisor.sv]
// Purpose: supervisory mode, reset, wake and bus transceiver control
// Assumes: analog comparators arrive as synchronous levels
// Notes:   flags clear by write-one pulses; set wins over clear
`timescale 1ns/10ps

// Functional notes
// - battery below off threshold forces off mode
// - battery recovery enters standby, sets power-on flag
// - split bit selects 85 or 50 mA
// - regulator undervoltage resets at selected threshold
// - 90 percent warning flag and state bit
// - transceiver active: normal, enabled, battery ok
// - receive output follows bus level while transceiver active, else recessive
// - standby bit gives low power with wake
// - standby or sleep, bit clear: powered down
// - bus wake needs minimum dominant time
// - transmit dominant time-out disables transmitter
// - per-pin edge configuration or disable
// - local wake: flag, or sleep to standby
// - level status only when a pin enabled
// - optional sampling on bias strobe rising edge
// - bias period selects 16 or 64 ms
// - interrupt pin low while any flag pending
// - bus wake flag clear keeps pending wake
// - cyclic interrupt on timeout-mode watchdog overflow
// - overtemperature: reset low, limp, supplies off
// - temperature recovery enters standby
// - overflow with cyclic pending causes reset
// - limp held set in overtemperature
module spw_supervisor #(
  parameter int unsigned TXD_TIMEOUT  = spw_pkg::TXD_TIMEOUT_CYC,
  parameter int unsigned BUS_WAKE_MIN = spw_pkg::BUS_WAKE_MIN_CYC,
  parameter int unsigned BIAS_SHORT   = spw_pkg::BIAS_SHORT_CYC,
  parameter int unsigned BIAS_LONG    = spw_pkg::BIAS_LONG_CYC
) (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               battery_above_poff,
  input  wire logic               battery_above_pon,
  input  wire logic               battery_above_bus_uv,
  input  wire logic               regulator_above_90,
  input  wire logic               regulator_above_70,
  input  wire logic               overtemp_detect,
  input  wire logic [1:0]         device_mode_field,
  input  wire logic               mode_write,
  input  wire logic               transceiver_standby_bit,
  input  wire logic               dissipation_split_bit,
  input  wire logic               reset_threshold_select,
  input  wire logic [1:0]         wake_a_edge_config,
  input  wire logic [1:0]         wake_b_edge_config,
  input  wire logic               wake_a_sample_enable,
  input  wire logic               wake_b_sample_enable,
  input  wire logic               wake_bias_period_select,
  input  wire logic               limp_clear,
  input  wire spw_pkg::spw_flags_t flag_clear,
  input  wire logic               local_wake_pin_a,
  input  wire logic               local_wake_pin_b,
  input  wire logic               bus_transmit_input,
  input  wire logic               bus_dominant,
  input  wire logic               watchdog_disable_pin,
  input  wire logic               watchdog_timeout_mode,
  input  wire logic               watchdog_overflow,
  output logic                    bus_receive_output,
  output logic                    bus_drive_dominant,
  output logic                    transceiver_active,
  output logic                    transceiver_lowpower,
  output logic                    transceiver_off,
  output logic                    regulator_enable,
  output logic                    pass_threshold_low,
  output logic                    regulator_state_bit,
  output logic                    reset_pin_low_o,
  output logic                    reset_pin_low_oe,
  output logic                    interrupt_out_low_o,
  output logic                    interrupt_out_low_oe,
  output logic                    limp_home_control_bit,
  output logic                    wake_bias_strobe,
  output logic                    wake_a_level_status,
  output logic                    wake_b_level_status,
  output spw_pkg::spw_flags_t     flags,
  output spw_pkg::spw_mode_t      mode
);

  // strobe toggles at half of each sampling period, so periods must be even
  if (TXD_TIMEOUT < 2 || BUS_WAKE_MIN < 2 || BIAS_SHORT < 4 ||
      BIAS_SHORT % 2 != 0 || BIAS_LONG % 2 != 0 || BIAS_LONG < BIAS_SHORT ||
      BIAS_LONG >= (1 << spw_pkg::TMR_W)) begin : g_bad_param
    $error("spw_supervisor: timing parameters out of range");
  end

  localparam logic [spw_pkg::TMR_W-1:0] TXD_LIM   = spw_pkg::TMR_W'(TXD_TIMEOUT - 1);
  localparam logic [spw_pkg::TMR_W-1:0] WAKE_LIM  = spw_pkg::TMR_W'(BUS_WAKE_MIN - 1);
  localparam logic [spw_pkg::TMR_W-1:0] SHORT_LIM = spw_pkg::TMR_W'(BIAS_SHORT / 2 - 1);
  localparam logic [spw_pkg::TMR_W-1:0] LONG_LIM  = spw_pkg::TMR_W'(BIAS_LONG / 2 - 1);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    spw_pkg::spw_mode_t        mode;
    spw_pkg::spw_flags_t       flags;
    logic [1:0]                txd_sync;
    logic                      txd_prev;
    logic [spw_pkg::TMR_W-1:0] txd_cnt;
    logic                      txd_timed_out;
    logic [1:0]                wa_sync;
    logic [1:0]                wb_sync;
    logic [1:0]                wake_smp;
    logic [spw_pkg::TMR_W-1:0] bus_cnt;
    logic                      bus_wake_pend;
    logic [spw_pkg::TMR_W-1:0] bias_cnt;
    logic                      bias;
    logic                      ci_enabled;
    logic                      sys_reset;
    logic                      limp;
    logic                      rx;
  } spw_state_t;

  spw_state_t st;
  spw_state_t next_st;

  logic [1:0] pin_sync;
  logic [1:0] edge_cfg;
  logic [1:0] smp_en;
  logic [1:0] smp_now;
  logic [1:0] wake_evt;
  logic       any_wake_enabled;
  logic       in_normal;
  logic       in_run;
  logic       bias_lim_hit;
  logic       bias_rise;

  assign pin_sync = {st.wb_sync[1], st.wa_sync[1]};
  assign smp_en   = {wake_b_sample_enable, wake_a_sample_enable};
  assign in_normal = (st.mode == spw_pkg::SPW_NORMAL);
  assign in_run    = in_normal || (st.mode == spw_pkg::SPW_STANDBY);
  assign any_wake_enabled = |edge_cfg;
  assign bias_lim_hit = wake_bias_period_select ? (st.bias_cnt >= LONG_LIM)
                                                : (st.bias_cnt >= SHORT_LIM);
  assign bias_rise    = bias_lim_hit && !st.bias;

  // ------------------------------------------------------------
  // wake pin edge detection, one lane per pin
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_wake
      logic [1:0] cfg;
      logic       rise;
      logic       fall;
      assign cfg  = (gi == 0) ? wake_a_edge_config : wake_b_edge_config;
      // strobe-gated sampling trades latency for bias current
      assign smp_now[gi] = smp_en[gi] ? bias_rise : 1'b1;
      assign rise = smp_now[gi] && pin_sync[gi] && !st.wake_smp[gi];
      assign fall = smp_now[gi] && !pin_sync[gi] && st.wake_smp[gi];
      assign wake_evt[gi] = ((cfg == spw_pkg::WCFG_RISE) && rise) ||
                            ((cfg == spw_pkg::WCFG_FALL) && fall) ||
                            ((cfg == spw_pkg::WCFG_BOTH) && (rise || fall));
      assign edge_cfg[gi] = |cfg;
    end
  endgenerate

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.sys_reset = 1'b0;

    // input synchronisers
    next_st.txd_sync = {st.txd_sync[0], bus_transmit_input};
    next_st.wa_sync  = {st.wa_sync[0], local_wake_pin_a};
    next_st.wb_sync  = {st.wb_sync[0], local_wake_pin_b};

    // bias strobe divider
    if (bias_lim_hit) begin
      next_st.bias_cnt = '0;
      next_st.bias     = ~st.bias;
    end else begin
      next_st.bias_cnt = st.bias_cnt + 1'b1;
    end

    // sampled wake levels
    for (int i = 0; i < 2; i++) begin
      if (smp_now[i]) begin
        next_st.wake_smp[i] = pin_sync[i];
      end
    end

    // transmit dominant time-out
    next_st.txd_prev = st.txd_sync[1];
    if (st.txd_sync[1] && !st.txd_prev) begin
      next_st.txd_cnt       = '0;
      next_st.txd_timed_out = 1'b0;
    end else if (!st.txd_sync[1] && st.txd_prev) begin
      next_st.txd_cnt = '0;
    end else if (!st.txd_sync[1] && !st.txd_timed_out) begin
      if (st.txd_cnt >= TXD_LIM) begin
        next_st.txd_timed_out = 1'b1;
      end else begin
        next_st.txd_cnt = st.txd_cnt + 1'b1;
      end
    end

    // bus wake filter while in low power
    if (transceiver_lowpower && bus_dominant) begin
      if (st.bus_cnt >= WAKE_LIM) begin
        next_st.bus_wake_pend = 1'b1;
      end else begin
        next_st.bus_cnt = st.bus_cnt + 1'b1;
      end
    end else begin
      next_st.bus_cnt = '0;
    end
    if (in_normal && !transceiver_standby_bit) begin
      next_st.bus_wake_pend = 1'b0;
    end

    // flag clears first so that sets below win
    next_st.flags = st.flags & ~flag_clear;

    if (!regulator_above_90 && in_run) begin
      next_st.flags.regulator_undervoltage_warning = 1'b1;
    end
    if (next_st.bus_wake_pend && !st.bus_wake_pend) begin
      next_st.flags.bus_wakeup_flag = 1'b1;
    end
    if (in_run) begin
      for (int i = 0; i < 2; i++) begin
        if (wake_evt[i]) begin
          next_st.flags.wake_flag[i] = 1'b1;
        end
      end
    end

    // cyclic interrupt
    next_st.ci_enabled = in_run && watchdog_timeout_mode && !watchdog_disable_pin;
    if (st.ci_enabled && watchdog_overflow) begin
      if (st.flags.cyclic_interrupt) begin
        next_st.sys_reset = 1'b1;
      end else begin
        next_st.flags.cyclic_interrupt = 1'b1;
      end
    end

    // regulator undervoltage reset
    if (in_run && (reset_threshold_select ? !regulator_above_70 : !regulator_above_90)) begin
      next_st.sys_reset = 1'b1;
    end

    if (limp_clear) begin
      next_st.limp = 1'b0;
    end

    // mode sequencing
    case (st.mode)
      spw_pkg::SPW_OFF: begin
        if (battery_above_pon) begin
          next_st.mode = spw_pkg::SPW_STANDBY;
          next_st.flags.power_on_flag = 1'b1;
          next_st.sys_reset = 1'b1;
        end
      end
      spw_pkg::SPW_STANDBY,
      spw_pkg::SPW_NORMAL: begin
        if (overtemp_detect) begin
          next_st.mode = spw_pkg::SPW_OVERTEMP;
        end else if (mode_write) begin
          case (device_mode_field)
            spw_pkg::MODE_STANDBY: next_st.mode = spw_pkg::SPW_STANDBY;
            spw_pkg::MODE_SLEEP:   next_st.mode = spw_pkg::SPW_SLEEP;
            default:               next_st.mode = spw_pkg::SPW_NORMAL;
          endcase
        end
      end
      spw_pkg::SPW_SLEEP: begin
        if (|wake_evt || st.bus_wake_pend) begin
          next_st.mode = spw_pkg::SPW_STANDBY;
        end
      end
      spw_pkg::SPW_OVERTEMP: begin
        next_st.limp = 1'b1;
        if (!overtemp_detect) begin
          next_st.mode = spw_pkg::SPW_STANDBY;
          next_st.sys_reset = 1'b1;
        end
      end
      default: next_st.mode = spw_pkg::SPW_OFF;
    endcase

    // battery loss overrides everything
    if (!battery_above_poff) begin
      next_st.mode          = spw_pkg::SPW_OFF;
      next_st.flags         = '0;
      next_st.bus_wake_pend = 1'b0;
      next_st.limp          = 1'b0;
      next_st.sys_reset     = 1'b0;
    end

    next_st.rx = transceiver_active ? !bus_dominant : 1'b1;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '{mode: spw_pkg::SPW_OFF, rx: 1'b1, txd_sync: 2'h3, txd_prev: 1'b1,
              default: '0};
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign mode  = st.mode;
  assign flags = st.flags;

  assign transceiver_active = in_normal && !transceiver_standby_bit &&
                              battery_above_bus_uv;
  assign transceiver_lowpower = transceiver_standby_bit &&
                                (st.mode != spw_pkg::SPW_OFF);
  assign transceiver_off = !transceiver_active && !transceiver_lowpower;
  assign bus_receive_output = st.rx;
  assign bus_drive_dominant = transceiver_active && !st.txd_timed_out &&
                              (st.mode != spw_pkg::SPW_OVERTEMP) &&
                              !st.txd_sync[1];

  assign regulator_enable = (st.mode != spw_pkg::SPW_OFF) &&
                            (st.mode != spw_pkg::SPW_OVERTEMP) &&
                            (st.mode != spw_pkg::SPW_SLEEP);
  assign pass_threshold_low  = dissipation_split_bit;
  assign regulator_state_bit = regulator_above_90;

  // reset pin: low in off mode, during overtemperature, or while the internal reset is high
  assign reset_pin_low_o  = 1'b0;
  assign reset_pin_low_oe = st.sys_reset || (st.mode == spw_pkg::SPW_OVERTEMP) ||
                            (st.mode == spw_pkg::SPW_OFF);

  assign interrupt_out_low_o  = 1'b0;
  assign interrupt_out_low_oe = |st.flags;

  assign limp_home_control_bit = st.limp || (st.mode == spw_pkg::SPW_OVERTEMP);
  assign wake_bias_strobe      = st.bias;

  assign wake_a_level_status = any_wake_enabled ? st.wake_smp[0] : 1'b0;
  assign wake_b_level_status = any_wake_enabled ? st.wake_smp[1] : 1'b0;

endmodule : spw_supervisor
